/* core/evm_pkg.sv */
// Constants for the exception vector mapping unit
package evm_pkg;
    // Table geometry
    localparam logic [31:0] VEC_TABLE_RESET_BASE = 32'h0000_0000; // Lowest 1024 bytes
    localparam int          VEC_TABLE_BYTES      = 1024;
    localparam int          VEC_ENTRY_BYTES      = 4;
    localparam int          VEC_COUNT            = 256;
    localparam logic [31:0] OFS_RESET_SSP        = 32'h0000_0000;
    localparam logic [31:0] OFS_RESET_PC         = 32'h0000_0004;
    // Fixed vector numbers
    localparam logic [7:0]  VEC_BUS_ERROR        = 8'h02; // Offset 008
    localparam logic [7:0]  VEC_ADDR_ERROR       = 8'h03; // Offset 00C
    localparam logic [7:0]  VEC_COP_ABSENT       = 8'h0B; // Offset 02C
    localparam logic [7:0]  VEC_COP_PROTOCOL     = 8'h0D; // Offset 034
    localparam logic [7:0]  VEC_UNINIT_INT       = 8'h0F; // Offset 03C
    localparam logic [7:0]  VEC_SPURIOUS         = 8'h18; // Offset 060
    localparam logic [7:0]  VEC_AUTO_L4          = 8'h1C; // Offset 070, disk interface
    localparam logic [7:0]  VEC_AUTO_L7          = 8'h1F; // Offset 07C, parity error
    localparam logic [7:0]  VEC_USER_FIRST       = 8'h40; // 64..255, offsets 100..3FF
    // Interrupt levels
    localparam logic [2:0]  LVL_PARITY           = 3'h7;
    localparam logic [2:0]  LVL_CIO              = 3'h6;
    localparam logic [2:0]  LVL_SERIAL           = 3'h5;
    localparam logic [2:0]  LVL_DISK             = 3'h4;
    localparam logic [2:0]  LVL_NONE             = 3'h0;
    // Counter/timer slots within the timer vector (bits 2:1)
    localparam logic [1:0]  CT_SLOT_T3           = 2'h0;
    localparam logic [1:0]  CT_SLOT_T2           = 2'h1;
    localparam logic [1:0]  CT_SLOT_T1           = 2'h2;
    localparam logic [1:0]  CT_SLOT_ERR          = 2'h3;
    // Bit positions of the timer request inputs
    localparam int          TMR_T1               = 0;
    localparam int          TMR_T2               = 1;
    localparam int          TMR_T3               = 2;
    localparam int          TMR_ERR              = 3;
    // Suggested vector base values, software loads these into the peripherals
    localparam logic [7:0]  SUGG_SER_BASE        = 8'h50;
    localparam logic [7:0]  SUGG_PA_BASE         = 8'h41;
    localparam logic [7:0]  SUGG_PB_BASE         = 8'h40;
    localparam logic [7:0]  SUGG_CT_BASE         = 8'h60;
    // Controller states
    typedef enum logic [2:0] {
        EVM_RST_SSP,
        EVM_RST_PC,
        EVM_IDLE,
        EVM_ACK,
        EVM_FETCH
    } evm_state_t;
endpackage

/* core/evm_prio_enc.sv */
// Priority encoder, highest index wins
`timescale 1ns/100ps
`default_nettype none
module evm_prio_enc
    import evm_pkg::*;
#(
    parameter int W = 8
) (
    // Requests
    input  wire logic [W-1:0]         req,
    // Result
    output logic                      any,
    output logic [$clog2(W)-1:0]      idx
);
    ////////////////////////////////////////////////////////////////////////////
    // Scan upward so the last hit (highest index) wins
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = 0; i < W; i++) begin
            if (req[i]) begin
                any = 1'b1;
                idx = i[$clog2(W)-1:0];
            end
        end
    end
endmodule // evm_prio_enc
`default_nettype wire

/* core/evm_vector_map.sv */
// Exception and interrupt vector selection and vector fetch sequencing
// Contract
// - Every vector entry is four bytes and reset fetches the stack pointer at 000 then the PC at 004.
// - The table base resets to zero and software may relocate it.
// - Device-supplied vectors lie in the user range 64 to 255, offsets 100 to 3FF.
// - Watchdog expiry and memory-management faults both take the bus error vector at 008.
// - An absent coprocessor uses offset 02C and a coprocessor protocol violation uses 034.
// - Parity errors autovector at level 7 (07C) and the disk interface at level 4 (070).
// - All other interrupt sources supply their own programmed vector number.
// - Level 6 order is timer 3, port A, timer 2, port B, timer 1, then timer error.
// - Port A vectors share five bits and encode the cause, 79 down to 65.
// - Port B carries the eight system-bus lines, line 0 at 78 down to line 7 at 64.
// - The serial controller uses level 5 with vectors 80 to 87, four causes per port.
// - Every source has an enable and the serial port priority is programmable.
// - The spurious vector 060 is never produced and the uninitialised vector is 03C.
// - Level 7 is non-maskable and lower levels need to exceed the current mask.
// - An interrupt is taken at an instruction boundary through an acknowledge step.
`timescale 1ns/100ps
`default_nettype none
module evm_vector_map
    import evm_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Processor state
    input  wire logic        inst_boundary,
    input  wire logic [2:0]  ipl_mask,
    input  wire logic        vbr_load,
    input  wire logic [31:0] vbr_value,
    // Fault events, one-cycle pulses
    input  wire logic        wdog_expire,
    input  wire logic        mmu_fault,
    input  wire logic        addr_fault,
    input  wire logic        cop_absent,
    input  wire logic        cop_protocol,
    // Autovectored sources
    input  wire logic        parity_irq,
    input  wire logic        parity_en,
    input  wire logic        disk_irq,
    input  wire logic        disk_en,
    // Counter/parallel unit sources
    input  wire logic [7:0]  pa_irq,
    input  wire logic [7:0]  pa_en,
    input  wire logic [7:0]  system_bus_irq_line,
    input  wire logic [7:0]  pb_en,
    input  wire logic [3:0]  tmr_irq,
    input  wire logic [3:0]  tmr_en,
    input  wire logic [7:0]  pa_base,
    input  wire logic [7:0]  pb_base,
    input  wire logic [7:0]  ct_base,
    // Dual serial controller sources
    input  wire logic [7:0]  ser_irq,
    input  wire logic [7:0]  ser_en,
    input  wire logic        ser_b_first,
    input  wire logic [7:0]  ser_base,
    // Vector fetch memory port
    input  wire logic        fetch_ack,
    input  wire logic [31:0] fetch_data,
    output logic             fetch_req,
    output logic [31:0]      fetch_addr,
    // Exception results
    output logic [7:0]       vector_num,
    output logic [2:0]       ack_level,
    output logic             iack_pulse,
    output logic             autovector,
    output logic [31:0]      handler_addr,
    output logic [31:0]      supervisor_stack_pointer,
    output logic             take_done
);
    ////////////////////////////////////////////////////////////////////////////
    // Enabled requests and encoders
    logic [7:0] pa_q, pb_rev, ser_q;
    logic [3:0] tmr_q;
    logic       pa_any, pb_any;
    logic [2:0] pa_idx, pb_idx;
    logic [1:0] ser_any;
    logic [1:0] ser_idx [2];

    assign pa_q  = pa_irq & pa_en;
    assign tmr_q = tmr_irq & tmr_en;
    assign ser_q = ser_irq & ser_en;

    evm_prio_enc #(.W(8)) u_pa_enc (
        .req (pa_q),
        .any (pa_any),
        .idx (pa_idx)
    );

    evm_prio_enc #(.W(8)) u_pb_enc (
        .req (pb_rev),
        .any (pb_any),
        .idx (pb_idx)
    );

    // Line 0 ranks first, so reverse it into the top slot of the encoder
    // Serial causes: receive ranks first within a port, hence the reversal too
    for (genvar g = 0; g < 8; g++) begin : g_rev
        assign pb_rev[g] = system_bus_irq_line[7-g] & pb_en[7-g];
    end

    for (genvar p = 0; p < 2; p++) begin : g_ser
        logic [3:0] cause_rev;
        logic [1:0] enc_idx;
        assign cause_rev = {ser_q[4*p], ser_q[4*p+1], ser_q[4*p+2], ser_q[4*p+3]};
        evm_prio_enc #(.W(4)) u_ser_enc (
            .req (cause_rev),
            .any (ser_any[p]),
            .idx (enc_idx)
        );
        assign ser_idx[p] = 2'h3 - enc_idx;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending level and vector selection
    logic       lvl7, lvl6, lvl5, lvl4;
    logic [2:0] pend_level;
    logic       pend_ok;
    logic [7:0] sel_vec;
    logic       sel_auto;
    logic       ser_use_b;

    assign lvl7 = parity_irq & parity_en;
    assign lvl6 = pa_any | pb_any | (|tmr_q);
    assign lvl5 = |ser_any;
    assign lvl4 = disk_irq & disk_en;
    assign ser_use_b = ser_any[1] & (ser_b_first | ~ser_any[0]);

    always_comb begin
        if (lvl7) begin
            pend_level = LVL_PARITY;
        end else if (lvl6) begin
            pend_level = LVL_CIO;
        end else if (lvl5) begin
            pend_level = LVL_SERIAL;
        end else if (lvl4) begin
            pend_level = LVL_DISK;
        end else begin
            pend_level = LVL_NONE;
        end
    end

    // Level 7 ignores the mask, all others must exceed it
    assign pend_ok = (pend_level == LVL_PARITY) ||
                     ((pend_level != LVL_NONE) && (pend_level > ipl_mask));

    // Vector for the level being acknowledged; a device base below the user
    // range means software never loaded it, so the uninitialised vector is used
    always_comb begin
        sel_vec  = VEC_UNINIT_INT;
        sel_auto = 1'b0;
        case (ack_level)
            LVL_PARITY: begin
                sel_vec  = VEC_AUTO_L7;
                sel_auto = 1'b1;
            end
            LVL_DISK: begin
                sel_vec  = VEC_AUTO_L4;
                sel_auto = 1'b1;
            end
            LVL_CIO: begin
                if (tmr_q[TMR_T3]) begin
                    sel_vec = {ct_base[7:3], CT_SLOT_T3, ct_base[0]};
                end else if (pa_any) begin
                    sel_vec = {pa_base[7:4], pa_idx, pa_base[0]};
                end else if (tmr_q[TMR_T2]) begin
                    sel_vec = {ct_base[7:3], CT_SLOT_T2, ct_base[0]};
                end else if (pb_any) begin
                    sel_vec = {pb_base[7:4], pb_idx, pb_base[0]};
                end else if (tmr_q[TMR_T1]) begin
                    sel_vec = {ct_base[7:3], CT_SLOT_T1, ct_base[0]};
                end else if (tmr_q[TMR_ERR]) begin
                    sel_vec = {ct_base[7:3], CT_SLOT_ERR, ct_base[0]};
                end
            end
            LVL_SERIAL: begin
                if (lvl5) begin
                    sel_vec = {ser_base[7:3], ser_use_b,
                               ser_use_b ? ser_idx[1] : ser_idx[0]};
                end
            end
            default: begin
                sel_vec = VEC_UNINIT_INT;
            end
        endcase
        // Device-supplied numbers must land in the user area
        if (!sel_auto && sel_vec < VEC_USER_FIRST) begin
            sel_vec = VEC_UNINIT_INT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    evm_state_t  state_reg, state_next;
    logic [31:0] vbr_reg, vbr_next;
    logic [31:0] tbase_reg, tbase_next;
    logic        fetch_req_reg, fetch_req_next;
    logic [31:0] fetch_addr_reg, fetch_addr_next;
    logic [7:0]  vec_reg, vec_next;
    logic [2:0]  lvl_reg, lvl_next;
    logic        iack_reg, iack_next;
    logic        auto_reg, auto_next;
    logic [31:0] hand_reg, hand_next;
    logic [31:0] ssp_reg, ssp_next;
    logic        done_reg, done_next;
    logic        fault_hit;
    logic [7:0]  fault_vec;

    // Fault ranking: bus error before the others
    always_comb begin
        fault_hit = 1'b1;
        if (wdog_expire || mmu_fault) begin
            fault_vec = VEC_BUS_ERROR;
        end else if (addr_fault) begin
            fault_vec = VEC_ADDR_ERROR;
        end else if (cop_absent) begin
            fault_vec = VEC_COP_ABSENT;
        end else if (cop_protocol) begin
            fault_vec = VEC_COP_PROTOCOL;
        end else begin
            fault_vec = VEC_UNINIT_INT;
            fault_hit = 1'b0;
        end
    end

    // Next-state logic
    always_comb begin
        state_next      = state_reg;
        vbr_next        = vbr_load ? vbr_value : vbr_reg;
        tbase_next      = tbase_reg;
        fetch_req_next  = fetch_req_reg;
        fetch_addr_next = fetch_addr_reg;
        vec_next        = vec_reg;
        lvl_next        = lvl_reg;
        iack_next       = 1'b0;
        auto_next       = auto_reg;
        hand_next       = hand_reg;
        ssp_next        = ssp_reg;
        done_next       = 1'b0;
        case (state_reg)
            EVM_RST_SSP: begin
                fetch_req_next  = 1'b1;
                fetch_addr_next = VEC_TABLE_RESET_BASE + OFS_RESET_SSP;
                if (fetch_ack && fetch_req_reg) begin
                    ssp_next        = fetch_data;
                    fetch_addr_next = VEC_TABLE_RESET_BASE + OFS_RESET_PC;
                    state_next      = EVM_RST_PC;
                end
            end
            EVM_RST_PC: begin
                if (fetch_ack) begin
                    hand_next      = fetch_data;
                    fetch_req_next = 1'b0;
                    done_next      = 1'b1;
                    state_next     = EVM_IDLE;
                end
            end
            EVM_IDLE: begin
                tbase_next = vbr_reg;
                if (fault_hit) begin
                    vec_next        = fault_vec;
                    lvl_next        = LVL_NONE;
                    auto_next       = 1'b0;
                    fetch_req_next  = 1'b1;
                    fetch_addr_next = vbr_reg + {22'h0, fault_vec, 2'h0};
                    state_next      = EVM_FETCH;
                end else if (pend_ok && inst_boundary) begin
                    lvl_next   = pend_level;
                    iack_next  = 1'b1;
                    state_next = EVM_ACK;
                end
            end
            EVM_ACK: begin
                // Vector is sampled one cycle after the level is presented
                vec_next        = sel_vec;
                auto_next       = sel_auto;
                fetch_req_next  = 1'b1;
                fetch_addr_next = tbase_reg + {22'h0, sel_vec, 2'h0};
                state_next      = EVM_FETCH;
            end
            EVM_FETCH: begin
                if (fetch_ack) begin
                    hand_next      = fetch_data;
                    fetch_req_next = 1'b0;
                    done_next      = 1'b1;
                    state_next     = EVM_IDLE;
                end
            end
            default: begin
                state_next = EVM_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg      <= EVM_RST_SSP;
            vbr_reg        <= VEC_TABLE_RESET_BASE;
            tbase_reg      <= VEC_TABLE_RESET_BASE;
            fetch_req_reg  <= 1'b0;
            fetch_addr_reg <= 32'h0000_0000;
            vec_reg        <= 8'h00;
            lvl_reg        <= LVL_NONE;
            iack_reg       <= 1'b0;
            auto_reg       <= 1'b0;
            hand_reg       <= 32'h0000_0000;
            ssp_reg        <= 32'h0000_0000;
            done_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            vbr_reg        <= vbr_next;
            tbase_reg      <= tbase_next;
            fetch_req_reg  <= fetch_req_next;
            fetch_addr_reg <= fetch_addr_next;
            vec_reg        <= vec_next;
            lvl_reg        <= lvl_next;
            iack_reg       <= iack_next;
            auto_reg       <= auto_next;
            hand_reg       <= hand_next;
            ssp_reg        <= ssp_next;
            done_reg       <= done_next;
        end
    end

    // Outputs straight from flip-flops
    assign fetch_req                = fetch_req_reg;
    assign fetch_addr               = fetch_addr_reg;
    assign vector_num               = vec_reg;
    assign ack_level                = lvl_reg;
    assign iack_pulse               = iack_reg;
    assign autovector               = auto_reg;
    assign handler_addr             = hand_reg;
    assign supervisor_stack_pointer = ssp_reg;
    assign take_done                = done_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_fetch_addr_calc: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_FETCH) |-> fetch_addr_reg == tbase_reg + {22'h0, vec_reg, 2'h0})
        else $error("vector fetch address not base plus four times vector");
    chk_reset_fetch_order: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_RST_SSP && fetch_req_reg && fetch_ack)
        |=> (fetch_addr_reg == OFS_RESET_PC) && (ssp_reg == $past(fetch_data)))
        else $error("reset fetch did not move from stack pointer to program counter");
    chk_base_default: assert property (@(posedge mclk)
        $fell(sys_rst) |-> (vbr_reg == 32'h0) && (fetch_addr_reg == 32'h0))
        else $error("table base not at zero after reset");
    chk_user_vector_range: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_FETCH && (lvl_reg == LVL_CIO || lvl_reg == LVL_SERIAL))
        |-> (vec_reg >= VEC_USER_FIRST) || (vec_reg == VEC_UNINIT_INT))
        else $error("device vector outside user area");
    chk_bus_error_vector: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_IDLE && (wdog_expire || mmu_fault))
        |=> (vec_reg == 8'h02) && (fetch_addr_reg == $past(vbr_reg) + 32'h8))
        else $error("watchdog or translation fault missed bus error vector");
    chk_cop_vectors: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_IDLE && !wdog_expire && !mmu_fault && !addr_fault && cop_absent)
        |=> vec_reg == 8'h0B)
        else $error("absent coprocessor missed its vector");
    chk_autovector_level: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_ACK && (lvl_reg == LVL_PARITY || lvl_reg == LVL_DISK))
        |=> autovector && (vec_reg == ((lvl_reg == LVL_PARITY) ? 8'h1F : 8'h1C)))
        else $error("autovectored level got wrong vector");
    chk_serial_vector: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_ACK && lvl_reg == LVL_SERIAL && ser_base == 8'h50 && lvl5)
        |=> (vec_reg >= 8'h50) && (vec_reg <= 8'h57) && !autovector)
        else $error("serial controller vector outside 80 to 87");
    chk_mask_honoured: assert property (@(posedge mclk) disable iff (sys_rst)
        iack_pulse |-> (ack_level == 3'h7) || (ack_level > $past(ipl_mask)))
        else $error("masked interrupt level acknowledged");
    chk_boundary_only: assert property (@(posedge mclk) disable iff (sys_rst)
        iack_pulse |-> $past(inst_boundary) ##1 (state_reg == EVM_FETCH) && fetch_req)
        else $error("interrupt taken off an instruction boundary");
    chk_no_spurious: assert property (@(posedge mclk) disable iff (sys_rst)
        vec_reg != VEC_SPURIOUS)
        else $error("spurious vector produced");
    chk_timer3_first: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_reg == EVM_ACK && lvl_reg == LVL_CIO && tmr_q[TMR_T3] && ct_base >= 8'h40)
        |=> vec_reg == {$past(ct_base[7:3]), 2'h0, $past(ct_base[0])})
        else $error("timer 3 not given top priority at level 6");

    cov_reset_done: cover property (@(posedge mclk) state_reg == EVM_RST_PC ##1 take_done);
    cov_level6_ack: cover property (@(posedge mclk) iack_pulse && ack_level == LVL_CIO);
    cov_level5_ack: cover property (@(posedge mclk) iack_pulse && ack_level == LVL_SERIAL);
    cov_bus_error:  cover property (@(posedge mclk) state_reg == EVM_IDLE && mmu_fault);
endmodule // evm_vector_map
`default_nettype wire

/* test/evm_vec_mem.sv */
// Memory model that answers the unit's vector fetches
`timescale 1ns/100ps
`default_nettype none
module evm_vec_mem (
    // Clock and answer delay
    input  wire logic        mclk,
    input  wire logic [3:0]  lat,
    // Fetch port
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_ack,
    output logic [31:0]      fetch_data
);
    int cnt = 0;
    initial fetch_ack = 1'h0;
    initial fetch_data = 32'h0;
    // Word holds its address in the upper half and its complement in the lower; idle data flips so stale use shows
    always @(posedge mclk) begin
        if (fetch_req && !fetch_ack && cnt < lat) begin
            cnt <= cnt + 1;
        end else if (fetch_req && !fetch_ack) begin
            cnt <= 0;
            fetch_ack <= 1'h1;
            fetch_data <= {fetch_addr[15:0], ~fetch_addr[15:0]};
        end else begin
            fetch_ack <= 1'h0;
            fetch_data <= ~fetch_data;
        end
    end
endmodule // evm_vec_mem
`default_nettype wire

/* test/evm_vector_map_test.sv */
// Self-checking bench for the vector map unit
`timescale 1ns/100ps
`default_nettype none
module evm_vector_map_test;
    import evm_pkg::*;
    // Stimulus and observed signals
    logic        mclk = 0, sys_rst = 1, inst_boundary = 1, vbr_load = 0, ser_b_first = 0;
    logic        parity_irq = 0, disk_irq = 0, parity_en = 1, disk_en = 1;
    logic        wdog_expire, mmu_fault, addr_fault, cop_absent, cop_protocol;
    logic        fetch_ack, fetch_req, iack_pulse, autovector, take_done;
    logic [4:0]  flt = 5'h0;
    logic [2:0]  ipl_mask = 3'h0, ack_level;
    logic [3:0]  tmr_irq = 4'h0, tmr_en = 4'hF, lat = 4'h0;
    logic [7:0]  pa_irq = 8'h0, system_bus_irq_line = 8'h0, ser_irq = 8'h0, vector_num;
    logic [7:0]  pa_en = 8'hFF, pb_en = 8'hFF, ser_en = 8'hFF;
    logic [7:0]  pa_base = SUGG_PA_BASE, pb_base = SUGG_PB_BASE;
    logic [7:0]  ct_base = SUGG_CT_BASE, ser_base = SUGG_SER_BASE;
    logic [31:0] vbr_value = 32'h0, tb = 32'h0, fetch_data, fetch_addr, handler_addr;
    logic [31:0] supervisor_stack_pointer;
    int          error_cnt = 0, cmp_count = 0;
    assign {wdog_expire, mmu_fault, addr_fault, cop_absent, cop_protocol} = flt;
    initial forever #4 mclk = ~mclk;
    evm_vector_map evm_vector_map_inst (.mclk, .sys_rst, .inst_boundary, .ipl_mask,
        .vbr_load, .vbr_value, .wdog_expire, .mmu_fault, .addr_fault, .cop_absent,
        .cop_protocol, .parity_irq, .parity_en, .disk_irq, .disk_en, .pa_irq, .pa_en,
        .system_bus_irq_line, .pb_en, .tmr_irq, .tmr_en, .pa_base, .pb_base, .ct_base,
        .ser_irq, .ser_en, .ser_b_first, .ser_base, .fetch_ack, .fetch_data, .fetch_req,
        .fetch_addr, .vector_num, .ack_level, .iack_pulse, .autovector, .handler_addr,
        .supervisor_stack_pointer, .take_done);
    evm_vec_mem evm_vec_mem_inst (.mclk, .lat, .fetch_req, .fetch_addr, .fetch_ack,
        .fetch_data);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Word the memory model returns for an address
    function automatic logic [31:0] md(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    // Bounded wait; sampled after the edge so its updates have landed
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (s !== 1'b1 && n < 100);
        if (s !== 1'b1) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    // Sources are dropped right after the acknowledge so none is taken twice
    task automatic take(input logic [7:0] v, input logic [2:0] lvl, input logic av);
        if (lvl != 3'h0) begin
            wait_hi(iack_pulse);
            chk(ack_level, lvl);
            @(posedge mclk) {parity_irq, disk_irq, pa_irq, tmr_irq} <= '0;
            {system_bus_irq_line, ser_irq} <= '0;
        end
        wait_hi(take_done);
        chk(vector_num, v);
        chk(autovector, av);
        chk(handler_addr, md(tb + {22'h0, v, 2'h0}));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_faults();
        logic [7:0] ev [5] = '{VEC_BUS_ERROR, VEC_BUS_ERROR, VEC_ADDR_ERROR,
                               VEC_COP_ABSENT, VEC_COP_PROTOCOL};
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk) flt <= 5'h10 >> i;
            lat <= 4'(i);
            @(posedge mclk) flt <= 5'h0;
            take(ev[i], 3'h0, 1'b0);
        end
        @(posedge mclk) vbr_load <= 1'b1;
        vbr_value <= 32'h0000_2000;
        @(posedge mclk) vbr_load <= 1'b0;
        flt <= 5'h10;
        @(posedge mclk) flt <= 5'h0;
        tb = 32'h0000_2000;
        take(VEC_BUS_ERROR, 3'h0, 1'b0);
        $display("fault test done");
    endtask
    task automatic t_irq();
        @(posedge mclk) ipl_mask <= 3'h7;
        parity_irq <= 1'b1;
        take(VEC_AUTO_L7, LVL_PARITY, 1'b1);
        @(posedge mclk) ipl_mask <= 3'h4;
        disk_irq <= 1'b1;
        repeat (12) @(posedge mclk);
        #1 chk(fetch_req, 1'b0);
        chk(vector_num, VEC_AUTO_L7);
        @(posedge mclk) ipl_mask <= 3'h3;
        take(VEC_AUTO_L4, LVL_DISK, 1'b1);
        @(posedge mclk) ipl_mask <= 3'h0;
        tmr_irq <= 4'h5;
        take(8'h60, LVL_CIO, 1'b0);
        @(posedge mclk) pa_irq <= 8'h20;
        system_bus_irq_line <= 8'h81;
        take(8'h4B, LVL_CIO, 1'b0);
        @(posedge mclk) system_bus_irq_line <= 8'h81;
        take(8'h4E, LVL_CIO, 1'b0);
        @(posedge mclk) system_bus_irq_line <= 8'h80;
        tmr_irq <= 4'h9;
        take(8'h40, LVL_CIO, 1'b0);
        @(posedge mclk) tmr_irq <= 4'h9;
        take(8'h64, LVL_CIO, 1'b0);
        @(posedge mclk) tmr_irq <= 4'h8;
        take(8'h66, LVL_CIO, 1'b0);
        @(posedge mclk) tmr_irq <= 4'h2;
        ser_irq <= 8'h06;
        take(8'h62, LVL_CIO, 1'b0);
        @(posedge mclk) ser_irq <= 8'h06;
        take(8'h51, LVL_SERIAL, 1'b0);
        @(posedge mclk) ser_b_first <= 1'b1;
        ser_irq <= 8'h11;
        take(8'h54, LVL_SERIAL, 1'b0);
        @(posedge mclk) ser_en <= 8'hEF;
        ser_irq <= 8'h11;
        take(8'h50, LVL_SERIAL, 1'b0);
        $display("interrupt test done");
    endtask
    // Boundary hold-off, enable gating and an unloaded device base
    task automatic t_gates();
        @(posedge mclk) inst_boundary <= 1'b0;
        pa_irq <= 8'h80;
        repeat (12) @(posedge mclk);
        // Vector must still be the last one taken by the interrupt test
        #1 chk(vector_num, 8'h50);
        chk(fetch_req, 1'b0);
        @(posedge mclk) inst_boundary <= 1'b1;
        pa_en <= 8'h7F;
        pa_irq <= 8'h82;
        parity_en <= 1'b0;
        parity_irq <= 1'b1;
        take(8'h43, LVL_CIO, 1'b0);
        @(posedge mclk) pa_en <= 8'hFF;
        parity_en <= 1'b1;
        ct_base <= 8'h08;
        tmr_irq <= 4'h4;
        take(VEC_UNINIT_INT, LVL_CIO, 1'b0);
        @(posedge mclk) ct_base <= SUGG_CT_BASE;
        $display("gating test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        lat <= 4'h3;
        wait_hi(take_done);
        chk(supervisor_stack_pointer, md(OFS_RESET_SSP));
        chk(handler_addr, md(OFS_RESET_PC));
        $display("reset test done");
        t_faults();
        t_irq();
        t_gates();
        tally_and_finish();
    end
endmodule // evm_vector_map_test
`default_nettype wire
